// ---- dacscd_pkg.sv ----
// Constants and field layouts of the serial command decoder.
// Assumes every file that uses it imports it; holds constants and one helper function.
package dacscd_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int WORD_BITS    = 24;
  localparam int OP_MSB       = 23;
  localparam int OP_LSB       = 22;
  localparam int ADDR_MSB     = 21;
  localparam int ADDR_LSB     = 16;
  localparam int DATA_MSB     = 15;
  localparam int DATA_LSB     = 2;
  localparam int PAY_MSB      = 15;
  localparam int CNT_W        = 5;
  localparam logic [4:0] CNT_FULL = 5'h18;
  localparam logic [4:0] CNT_OVER = 5'h19;

  // ----------------------------------------------------------------------
  // Operation bits and write targets
  // ----------------------------------------------------------------------
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_GAIN    = 2'h1;
  localparam logic [1:0] OP_OFFSET  = 2'h2;
  localparam logic [1:0] OP_INPUT   = 2'h3;
  localparam logic [1:0] TGT_IN_A   = 2'h0;
  localparam logic [1:0] TGT_IN_B   = 2'h1;
  localparam logic [1:0] TGT_OFFSET = 2'h2;
  localparam logic [1:0] TGT_GAIN   = 2'h3;

  // ----------------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------------
  localparam int NUM_GROUPS = 5;
  localparam int GROUP_CH   = 8;
  localparam int NUM_CH     = 40;
  localparam logic [2:0] UP_BROAD   = 3'h0;
  localparam logic [2:0] UP_ALL5    = 3'h6;
  localparam logic [2:0] UP_UPPER4  = 3'h7;
  localparam logic [2:0] LO_GRP_MAX = 3'h5;

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  localparam logic [5:0] FN_NOP     = 6'h00;
  localparam logic [5:0] FN_CTRL    = 6'h01;
  localparam logic [5:0] FN_OFFSET_WORD_0    = 6'h02;
  localparam logic [5:0] FN_OFFSET_WORD_2    = 6'h04;
  localparam logic [5:0] FN_RDSEL   = 6'h05;
  localparam logic [5:0] FN_BSEL0   = 6'h06;
  localparam logic [5:0] FN_BSEL4   = 6'h0A;
  localparam logic [5:0] FN_BSELALL = 6'h0B;

  // ----------------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTL_PD   = 0;
  localparam int CTL_TSD  = 1;
  localparam int CTL_BANK = 2;
  localparam int OFS_W    = 14;
  localparam int BSEL_W   = 8;
  localparam logic [13:0] OFS_RESET  = 14'h0000;
  localparam logic [7:0]  BSEL_RESET = 8'h00;
  localparam logic        CTL_RESET  = 1'b0;

  // ----------------------------------------------------------------------
  // Readback selection: payload bits 15..13 type, 12..7 address
  // ----------------------------------------------------------------------
  localparam int RB_TYPE_MSB = 15;
  localparam int RB_TYPE_LSB = 13;
  localparam int RB_ADR_MSB  = 12;
  localparam int RB_ADR_LSB  = 7;
  localparam logic [2:0] RB_TYPE_REG = 3'h4;
  localparam logic [5:0] RB_CTRL  = 6'h01;
  localparam logic [5:0] RB_OFFSET_WORD_0  = 6'h02;
  localparam logic [5:0] RB_OFFSET_WORD_1  = 6'h03;
  localparam logic [5:0] RB_OFFSET_WORD_2  = 6'h04;
  localparam logic [5:0] RB_BSEL0 = 6'h06;
  localparam logic [5:0] RB_BSEL1 = 6'h07;
  localparam logic [5:0] RB_BSEL2 = 6'h08;
  localparam logic [5:0] RB_BSEL3 = 6'h09;
  localparam logic [5:0] RB_BSEL4 = 6'h0A;
  localparam logic [5:0] RB_CH_FIRST = 6'h08;
  localparam logic [5:0] RB_CH_LAST  = 6'h2F;

  // Absolute channel from a group-plus-one code and a channel number.
  function automatic logic [5:0] dacscd_abs_ch(input logic [2:0] grp_code,
                                               input logic [2:0] ch);
    logic [2:0] grp;
    grp = grp_code - 3'h1;
    dacscd_abs_ch = {grp, ch};
  endfunction

endpackage

// ---- dacscd_chan_decode.sv ----
// Expands the six address bits of a data write into a channel mask.
// Purely combinational itself; assumes the caller registers the mask.
`timescale 1ns/1ps
`default_nettype none
module dacscd_chan_decode
  import dacscd_pkg::*;
(
  input  wire logic [5:0]  addr,
  output logic      [39:0] mask
);
  wire logic [2:0] upper = addr[5:3];
  wire logic [2:0] lower = addr[2:0];

  genvar g;
  genvar c;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
      for (c = 0; c < GROUP_CH; c++) begin : gen_ch
        wire logic single = (upper == 3'(g + 1)) && (lower == 3'(c));
        wire logic whole  = (upper == UP_BROAD) &&
                            ((lower == 3'h0) || (lower == 3'(g + 1)));
        wire logic across = (lower == 3'(c)) &&
                            ((upper == UP_ALL5) ||
                             ((upper == UP_UPPER4) && (g != 0)));
        assign mask[g * GROUP_CH + c] = single | whole | across;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- dacscd_top.sv ----
// Serial command decoder: frames 24-bit words, executes special functions,
// raises channel writes and serves readback on the serial output.
// Assumes sclk, sync_n, serial_in and overtemp are asynchronous pins and
// that channel register contents come from outside on chan_rd_data.
`timescale 1ns/1ps
`default_nettype none
module dacscd_top
  import dacscd_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      sclk,
  input  wire logic                      sync_n,
  input  wire logic                      serial_in,
  input  wire logic                      overtemp,
  input  wire logic [dacscd_pkg::OFS_W-1:0] chan_rd_data,
  output logic                           serial_out,
  output logic                           serial_out_oe_n,
  output logic                           chan_wr_stb,
  output logic      [1:0]                chan_wr_target,
  output logic      [dacscd_pkg::NUM_CH-1:0] chan_wr_mask,
  output logic      [dacscd_pkg::OFS_W-1:0] chan_wr_data,
  output logic      [2:0]                chan_rd_type,
  output logic      [5:0]                chan_rd_index,
  output logic                           bank_b_sel,
  output logic                           thermal_shdn_en,
  output logic                           soft_pwr_down,
  output logic      [dacscd_pkg::OFS_W-1:0] offset_word_0,
  output logic      [dacscd_pkg::OFS_W-1:0] offset_word_1,
  output logic      [dacscd_pkg::OFS_W-1:0] offset_word_2,
  output logic      [dacscd_pkg::BSEL_W-1:0] bank_select_0,
  output logic      [dacscd_pkg::BSEL_W-1:0] bank_select_1,
  output logic      [dacscd_pkg::BSEL_W-1:0] bank_select_2,
  output logic      [dacscd_pkg::BSEL_W-1:0] bank_select_3,
  output logic      [dacscd_pkg::BSEL_W-1:0] bank_select_4
);
  import dacscd_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [2:0] sclk_r;
  logic [2:0] sync_r;
  logic [1:0] sdi_r;
  logic [1:0] otemp_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_r  <= 3'h7;
      sync_r  <= 3'h7;
      sdi_r   <= 2'h0;
      otemp_r <= 2'h0;
    end else begin
      sclk_r  <= {sclk_r[1:0], sclk};
      sync_r  <= {sync_r[1:0], sync_n};
      sdi_r   <= {sdi_r[0], serial_in};
      otemp_r <= {otemp_r[0], overtemp};
    end
  end

  wire logic sclk_fall   = sclk_r[2] & ~sclk_r[1];
  wire logic frame_start = sync_r[2] & ~sync_r[1];
  wire logic frame_end   = ~sync_r[2] & sync_r[1];
  wire logic in_frame    = ~sync_r[1];
  wire logic otemp_s     = otemp_r[1];

  // ----------------------------------------------------------------------
  // Shift-in of the command word
  // ----------------------------------------------------------------------
  logic [WORD_BITS-1:0] rx_r;
  logic [CNT_W-1:0]     cnt_r;

  // Sampling on the falling edge, first bit in lands at the top: MSB first.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_r  <= '0;
      cnt_r <= '0;
    end else if (frame_start) begin
      cnt_r <= '0;
    end else if (in_frame && sclk_fall) begin
      rx_r  <= {rx_r[WORD_BITS-2:0], sdi_r[1]};
      cnt_r <= (cnt_r == CNT_OVER) ? cnt_r : cnt_r + 5'h01;
    end
  end

  // Short frames abort; extra clocks corrupt the word, so it is dropped too.
  wire logic word_ok = frame_end && (cnt_r == CNT_FULL);

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire logic [1:0]  op_sel   = rx_r[OP_MSB:OP_LSB];
  wire logic        op_select_hi = op_sel[1];
  wire logic        op_select_lo = op_sel[0];
  wire logic [5:0]  function_code = rx_r[ADDR_MSB:ADDR_LSB];
  wire logic [15:0] function_payload = rx_r[PAY_MSB:0];
  wire logic [OFS_W-1:0] data_word = rx_r[DATA_MSB:DATA_LSB];
  wire logic        special  = word_ok && !op_select_hi && !op_select_lo;
  wire logic        data_wr  = word_ok && (op_select_hi || op_select_lo);
  wire logic [NUM_CH-1:0] addr_mask;

  dacscd_chan_decode u_decode (
    .addr (function_code),
    .mask (addr_mask)
  );

  wire logic fn_ctrl   = special && (function_code == FN_CTRL);
  wire logic fn_rdsel  = special && (function_code == FN_RDSEL);
  wire logic fn_bsall  = special && (function_code == FN_BSELALL);
  wire logic fn_ofs    = special && (function_code >= FN_OFFSET_WORD_0) &&
                         (function_code <= FN_OFFSET_WORD_2);
  wire logic fn_bsel   = special && (function_code >= FN_BSEL0) &&
                         (function_code <= FN_BSEL4);
  wire logic [1:0] ofs_idx  = 2'(function_code - FN_OFFSET_WORD_0);
  wire logic [2:0] bsel_idx = 3'(function_code - FN_BSEL0);

  // ----------------------------------------------------------------------
  // Special-function registers
  // ----------------------------------------------------------------------
  logic [OFS_W-1:0]  ofs_r  [3];
  logic [BSEL_W-1:0] bsel_r [NUM_GROUPS];
  logic              bank_r;
  logic              tsd_r;
  logic              pd_r;

  // Codes outside the decoded set fall through untouched, NO_OPERATION included.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bank_r <= CTL_RESET;
      tsd_r  <= CTL_RESET;
      pd_r   <= CTL_RESET;
      for (int i = 0; i < 3; i++) ofs_r[i] <= OFS_RESET;
      for (int i = 0; i < NUM_GROUPS; i++) bsel_r[i] <= BSEL_RESET;
    end else begin
      if (fn_ctrl) begin
        bank_r <= function_payload[CTL_BANK];
        tsd_r  <= function_payload[CTL_TSD];
        pd_r   <= function_payload[CTL_PD];
      end
      if (fn_ofs) ofs_r[ofs_idx] <= function_payload[OFS_W-1:0];
      if (fn_bsel) bsel_r[bsel_idx] <= function_payload[BSEL_W-1:0];
      if (fn_bsall) begin
        for (int i = 0; i < NUM_GROUPS; i++) begin
          bsel_r[i] <= function_payload[BSEL_W-1:0];
        end
      end
    end
  end

  // Control word as seen on readback; bit 4 follows the pin, bit 3 is zero.
  wire logic [4:0] ctrl_view = {otemp_s, 1'b0, bank_r, tsd_r, pd_r};

  // ----------------------------------------------------------------------
  // Channel data writes
  // ----------------------------------------------------------------------
  wire logic [1:0] tgt_sel = (op_sel == OP_INPUT)  ? (bank_r ? TGT_IN_B : TGT_IN_A) :
                             (op_sel == OP_OFFSET) ? TGT_OFFSET : TGT_GAIN;
  wire logic wr_hit = data_wr && (|addr_mask);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_wr_stb    <= 1'b0;
      chan_wr_target <= TGT_IN_A;
      chan_wr_mask   <= '0;
      chan_wr_data   <= '0;
    end else begin
      chan_wr_stb <= wr_hit;
      if (wr_hit) begin
        chan_wr_target <= tgt_sel;
        chan_wr_mask   <= addr_mask;
        chan_wr_data   <= data_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Readback selection and shift-out
  // ----------------------------------------------------------------------
  logic [2:0]           rb_type_r;
  logic [5:0]           rb_adr_r;
  logic                 rb_pend_r;
  logic                 tx_act_r;
  logic [WORD_BITS-1:0] tx_r;

  wire logic ch_type = (rb_type_r < RB_TYPE_REG);
  wire logic ch_ok   = ch_type && (rb_adr_r >= RB_CH_FIRST) &&
                       (rb_adr_r <= RB_CH_LAST);
  wire logic [OFS_W-1:0] reg_view =
    (rb_type_r != RB_TYPE_REG) ? '0 :
    (rb_adr_r == RB_CTRL)  ? OFS_W'(ctrl_view) :
    (rb_adr_r == RB_OFFSET_WORD_0)  ? ofs_r[0] :
    (rb_adr_r == RB_OFFSET_WORD_1)  ? ofs_r[1] :
    (rb_adr_r == RB_OFFSET_WORD_2)  ? ofs_r[2] :
    (rb_adr_r == RB_BSEL0) ? OFS_W'(bsel_r[0]) :
    (rb_adr_r == RB_BSEL1) ? OFS_W'(bsel_r[1]) :
    (rb_adr_r == RB_BSEL2) ? OFS_W'(bsel_r[2]) :
    (rb_adr_r == RB_BSEL3) ? OFS_W'(bsel_r[3]) :
    (rb_adr_r == RB_BSEL4) ? OFS_W'(bsel_r[4]) : '0;
  wire logic [OFS_W-1:0] rb_value = ch_ok ? chan_rd_data : reg_view;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rb_type_r <= 3'h0;
      rb_adr_r  <= 6'h00;
      rb_pend_r <= 1'b0;
      tx_act_r  <= 1'b0;
      tx_r      <= '0;
    end else begin
      if (fn_rdsel) begin
        rb_type_r <= function_payload[RB_TYPE_MSB:RB_TYPE_LSB];
        rb_adr_r  <= function_payload[RB_ADR_MSB:RB_ADR_LSB];
        rb_pend_r <= 1'b1;
      end else if (frame_start && rb_pend_r) begin
        rb_pend_r <= 1'b0;
      end
      if (frame_start) begin
        tx_act_r <= rb_pend_r;
        tx_r     <= {8'h00, rb_value, 2'h0};
      end else if (frame_end) begin
        tx_act_r <= 1'b0;
      end else if (in_frame && sclk_fall && tx_act_r) begin
        tx_r <= {tx_r[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // Channel readback needs the addressed register steady before the frame.
  assign chan_rd_type    = rb_type_r;
  assign chan_rd_index   = ch_ok ? dacscd_abs_ch(rb_adr_r[5:3], rb_adr_r[2:0]) : 6'h00;
  assign serial_out      = tx_r[WORD_BITS-1];
  assign serial_out_oe_n = ~(rb_pend_r | tx_act_r);

  assign bank_b_sel      = bank_r;
  assign thermal_shdn_en = tsd_r;
  assign soft_pwr_down   = pd_r;
  assign offset_word_0   = ofs_r[0];
  assign offset_word_1   = ofs_r[1];
  assign offset_word_2   = ofs_r[2];
  assign bank_select_0   = bsel_r[0];
  assign bank_select_1   = bsel_r[1];
  assign bank_select_2   = bsel_r[2];
  assign bank_select_3   = bsel_r[3];
  assign bank_select_4   = bsel_r[4];
endmodule
`default_nettype wire

// ---- dacscd_chk.sv ----
// Concurrent checks on the ports of the serial command decoder.
// Assumes it is bound to dacscd_top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module dacscd_chk
  import dacscd_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic                          sync_n,
  input wire logic                          serial_out_oe_n,
  input wire logic                          chan_wr_stb,
  input wire logic [dacscd_pkg::NUM_CH-1:0] chan_wr_mask,
  input wire logic                          bank_b_sel,
  input wire logic                          thermal_shdn_en,
  input wire logic                          soft_pwr_down,
  input wire logic [dacscd_pkg::OFS_W-1:0]  offset_word_0,
  input wire logic [dacscd_pkg::BSEL_W-1:0] bank_select_4
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Eight low cycles put any pending execution safely in the past.
  sequence in_frame_s;
    (!sync_n) [*8];
  endsequence
  stb_pulse_a: assert property (chan_wr_stb |=> !chan_wr_stb)
    else $error("channel write strobe longer than one cycle");
  stb_late_a: assert property (chan_wr_stb |-> $past(sync_n) && $past(sync_n, 2))
    else $error("channel write strobe not after frame end");
  mask_shape_a: assert property (chan_wr_stb |->
    $countones(chan_wr_mask) inside {1, 4, 5, 8, 40})
    else $error("channel mask has an impossible shape");
  ctl_hold_a: assert property (in_frame_s |->
    $stable({bank_b_sel, thermal_shdn_en, soft_pwr_down}))
    else $error("control bits changed inside a frame");
  ofs_hold_a: assert property (in_frame_s |-> $stable(offset_word_0))
    else $error("offset word changed inside a frame");
  frame_quiet_a: assert property (in_frame_s |-> !chan_wr_stb)
    else $error("channel write inside a frame");
  bsel_late_a: assert property ($changed(bank_select_4) |->
    $past(sync_n) && $past(sync_n, 2))
    else $error("bank select changed before frame end");
  oe_open_a: assert property ($fell(serial_out_oe_n) |-> $past(sync_n) && $past(sync_n, 2))
    else $error("serial output enabled inside a frame");
  oe_close_a: assert property ($rose(serial_out_oe_n) |-> $past(sync_n) && $past(sync_n, 2))
    else $error("serial output released inside a frame");
  all_cov: cover property (chan_wr_stb && (&chan_wr_mask));
  rd_cov: cover property ($fell(serial_out_oe_n));
  bsel_cov: cover property ($changed(bank_select_4));
endmodule
bind dacscd_top dacscd_chk u_chk (
  .ref_clk(ref_clk), .rst(rst), .sync_n(sync_n), .serial_out_oe_n(serial_out_oe_n),
  .chan_wr_stb(chan_wr_stb), .chan_wr_mask(chan_wr_mask), .bank_b_sel(bank_b_sel),
  .thermal_shdn_en(thermal_shdn_en), .soft_pwr_down(soft_pwr_down),
  .offset_word_0(offset_word_0), .bank_select_4(bank_select_4)
);
`default_nettype wire

// ---- dacscd_host.sv ----
// Serial master model: frames words MSB first and captures the serial output.
// Assumes it is called right after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dacscd_host (
  input  wire logic ref_clk,
  input  wire logic serial_out,
  output var logic  sclk,
  output var logic  sync_n,
  output var logic  serial_in
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    serial_in = 1'b0;
  end
  // Four reference cycles per half period give an 80 ns serial clock,
  // and the clock stands high between frames.
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    sync_n <= 1'b0;
    serial_in <= w[23];
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge ref_clk);
      rx = {rx[22:0], serial_out};
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      // Past the last bit the line shows the inverse, never a stale value.
      serial_in <= (i < 23) ? w[22-i] : ~w[0];
    end
    repeat (4) @(posedge ref_clk);
    sync_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- dacscd_tb.sv ----
// Self-checking bench for the serial command decoder.
// Assumes dacscd_host drives the serial pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dacscd_pkg::*;
  logic ref_clk, rst, overtemp, sclk, sync_n, serial_in, serial_out, serial_out_oe_n;
  logic chan_wr_stb, bank_b_sel, thermal_shdn_en, soft_pwr_down;
  logic [1:0] chan_wr_target;
  logic [2:0] chan_rd_type, ctl_e;
  logic [5:0] chan_rd_index;
  logic [13:0] chan_rd_data, chan_wr_data, offset_word_0, offset_word_1, offset_word_2;
  logic [39:0] chan_wr_mask;
  logic [7:0] bank_select_0, bank_select_1, bank_select_2, bank_select_3, bank_select_4;
  logic [13:0] ofs_e [3];
  logic [7:0] bs_e [5];
  logic [23:0] rx;
  int fail_count = 0, cmp_count = 0, stb_n = 0;
  dacscd_top dut (.*);
  dacscd_host u_host (.ref_clk(ref_clk), .serial_out(serial_out), .sclk(sclk),
    .sync_n(sync_n), .serial_in(serial_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (chan_wr_stb === 1'b1) stb_n <= stb_n + 1;
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic send(input logic [23:0] w);
    u_host.frame(w, 24, rx);
  endtask
  task automatic chk_cfg();
    chk("ctrl", ctl_e, {bank_b_sel, thermal_shdn_en, soft_pwr_down});
    chk("offset_word_0", ofs_e[0], offset_word_0);
    chk("offset_word_1", ofs_e[1], offset_word_1);
    chk("offset_word_2", ofs_e[2], offset_word_2);
    chk("bsel0", bs_e[0], bank_select_0);
    chk("bsel1", bs_e[1], bank_select_1);
    chk("bsel2", bs_e[2], bank_select_2);
    chk("bsel3", bs_e[3], bank_select_3);
    chk("bsel4", bs_e[4], bank_select_4);
  endtask
  // Payload bits 4 and 3 always go out as zero.
  task automatic ctrl(input logic [2:0] f);
    ctl_e = f;
    send({2'b00, FN_CTRL, 11'h000, 2'b00, f});
    chk_cfg();
  endtask
  function automatic logic [39:0] exp_mask(input logic [5:0] a);
    logic [39:0] m;
    m = 40'h0;
    for (int g = 0; g < 5; g++)
      for (int c = 0; c < 8; c++)
        if ((a[5:3] == 3'(g + 1) && a[2:0] == 3'(c)) || (a[5:3] == 3'h6 && a[2:0] == 3'(c)) ||
            (a[5:3] == 3'h0 && (a[2:0] == 3'h0 || a[2:0] == 3'(g + 1))) ||
            (a[5:3] == 3'h7 && g > 0 && a[2:0] == 3'(c)))
          m[g * 8 + c] = 1'b1;
    return m;
  endfunction
  task automatic wr_chan(input logic [1:0] op, input logic [5:0] a, input logic [13:0] d);
    int n0;
    logic [39:0] m;
    logic [1:0] t;
    n0 = stb_n;
    m = exp_mask(a);
    t = (op == OP_OFFSET) ? TGT_OFFSET : (op == OP_GAIN) ? TGT_GAIN : TGT_IN_A;
    if (op == OP_INPUT && ctl_e[2]) t = TGT_IN_B;
    send({op, a, d, 2'b00});
    chk("strobes", (m != 40'h0) ? 40'h1 : 40'h0, 40'(stb_n - n0));
    if (m != 40'h0) begin
      chk("mask", m, chan_wr_mask);
      chk("target", t, chan_wr_target);
      chk("data", d, chan_wr_data);
    end
  endtask
  task automatic rdback(input logic [15:0] sel, input logic [13:0] exp);
    send({2'b00, FN_RDSEL, sel});
    chk("oe_n", 40'h0, serial_out_oe_n);
    chk_cfg();
    u_host.frame(24'h000000, 24, rx);
    chk("readback", {8'h00, exp, 2'b00}, rx);
    chk("oe_n", 40'h1, serial_out_oe_n);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    overtemp = 1'b0;
    chan_rd_data = 14'h0000;
    ctl_e = 3'h0;
    foreach (ofs_e[k]) ofs_e[k] = OFS_RESET;
    foreach (bs_e[k]) bs_e[k] = BSEL_RESET;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("oe_n", 40'h1, serial_out_oe_n);
    chk_cfg();
    ctrl(3'b101);
    ctrl(3'b010);
    ctrl(3'b100);
    for (int a = 0; a < 64; a++) begin
      if (a == 32) ctrl(3'b011);
      wr_chan(2'(a % 3 + 1), 6'(a), {6'(a), 8'hA5});
    end
    for (int k = 0; k < 3; k++) begin
      ofs_e[k] = 14'h1C3A + 14'(k);
      send({2'b00, 6'(2 + k), 2'b11, ofs_e[k]});
      chk_cfg();
    end
    for (int k = 0; k < 5; k++) begin
      bs_e[k] = 8'h30 + 8'(k);
      send({2'b00, 6'(6 + k), 8'hFF, bs_e[k]});
      chk_cfg();
    end
    for (int v = 0; v < 2; v++) begin
      foreach (bs_e[k]) bs_e[k] = v ? 8'h00 : 8'hFF;
      send({2'b00, FN_BSELALL, 8'h00, bs_e[0]});
      chk_cfg();
    end
    send({2'b00, 6'h1C, 16'hFFFF});
    send(24'h000000);
    u_host.frame({2'b00, FN_OFFSET_WORD_0, 16'h3FFF}, 23, rx);
    u_host.frame({2'b00, FN_OFFSET_WORD_2, 16'h0001}, 25, rx);
    chk_cfg();
    overtemp <= 1'b1;
    chan_rd_data <= 14'h2D4B;
    rdback({3'h4, RB_CTRL, 7'h00}, {9'h000, 1'b1, 1'b0, ctl_e});
    rdback({3'h4, RB_OFFSET_WORD_1, 7'h00}, ofs_e[1]);
    rdback({3'h4, RB_BSEL3, 7'h00}, {6'h00, bs_e[3]});
    rdback({3'h1, RB_CH_LAST, 7'h00}, 14'h2D4B);
    chk("rd_type", 40'h1, chan_rd_type);
    chk("rd_index", 40'd39, chan_rd_index);
    rdback({3'h4, 6'h05, 7'h00}, 14'h0000);
    rdback({3'h2, 6'h30, 7'h00}, 14'h0000);
    chk("rd_type", 40'h2, chan_rd_type);
    chk("rd_index", 40'h0, chan_rd_index);
    print_verdict();
  end
endmodule
`default_nettype wire
